// *** verilog/spdpc_device.sv ***
// Purpose: Driver side: winding gating, fault latches, overcurrent blanking
// Assumes: Comparator and thermal inputs are asynchronous to clk_sys
// Notes: Overview of operation
//
// Overview of operation
// - Enable low forces all windings off
// - Enable low freezes state except reset
// - Fault line pulled low on latched fault
// - Faults latch, windings off until reset
// - Host recovers with reset high-low-high
// - Ignore overcurrent 5.5 us each chop
// - Over-threshold current comparator trips latch
// - Over-temperature comparator trips latch
// - Power-on reset initialises internal logic
// - Host keeps enable low under 4.75 V
// - Reset tied high without external reset
// - Host slows down before stopping steps
// - Active-low phases, complementary never both on
// - Reset input low holds device reset
// - Reset release starts at A and BB
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "spdpc_defs.svh"
module spdpc_device (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    spdpc_if.device link,
    input wire logic chop_start,
    input wire logic over_current_raw,
    input wire logic over_temp_raw,
    output logic [3:0] winding_on,
    output logic fault_oc,
    output logic fault_ot
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [3:0] ph_s1;
        logic [3:0] ph_s2;
        logic [1:0] en_sync;
        logic [1:0] oc_sync;
        logic [1:0] ot_sync;
        logic [1:0] chop_sync;
        logic chop_prev;
        logic [`SPDPC_BLANK_W-1:0] blank_cnt;
        logic oc_latch;
        logic ot_latch;
        logic [3:0] drive;
    } spdpc_dev_state_t;

    spdpc_dev_state_t st_q;
    spdpc_dev_state_t st_d;

    // Pair decode: on only when exactly one side of the pair is asserted.
    // Result is {positive winding, bar winding}; inputs are active low.
    function automatic logic [1:0] spdpc_pair(input logic pos_low, input logic neg_low);
        logic pos_on;
        logic neg_on;
        pos_on = ~pos_low & neg_low;
        neg_on = ~neg_low & pos_low;
        spdpc_pair = {pos_on, neg_on};
    endfunction

    logic gate_open;
    logic ext_reset;
    logic chop_edge;
    logic [1:0] pair_a;
    logic [1:0] pair_b;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        // Reset pin is never frozen by enable, so it is sampled every clock
        st_d.rst_sync = {st_q.rst_sync[0], link.system_reset_low};
        st_d.en_sync = {st_q.en_sync[0], link.enable};
        ext_reset = ~st_q.rst_sync[1];
        chop_edge = st_q.chop_sync[1] & ~st_q.chop_prev;
        pair_a = spdpc_pair(st_q.ph_s2[3], st_q.ph_s2[2]);
        pair_b = spdpc_pair(st_q.ph_s2[1], st_q.ph_s2[0]);
        if (ext_reset) begin
            // Holding reset restarts the excitation at A and BB
            st_d.oc_latch = 1'b0;
            st_d.ot_latch = 1'b0;
            st_d.blank_cnt = '0;
            st_d.ph_s1 = `SPDPC_PHASE_INIT;
            st_d.ph_s2 = `SPDPC_PHASE_INIT;
            st_d.drive = `SPDPC_DRIVE_INIT;
        end else if (st_q.en_sync[1]) begin
            st_d.ph_s1 = {link.phase_a_drive_low, link.phase_a_bar_drive_low,
                          link.phase_b_drive_low, link.phase_b_bar_drive_low};
            st_d.ph_s2 = st_q.ph_s1;
            st_d.oc_sync = {st_q.oc_sync[0], over_current_raw};
            st_d.ot_sync = {st_q.ot_sync[0], over_temp_raw};
            st_d.chop_sync = {st_q.chop_sync[0], chop_start};
            st_d.chop_prev = st_q.chop_sync[1];
            if (chop_edge) begin
                st_d.blank_cnt = `SPDPC_BLANK_W'(`SPDPC_BLANK_CYCLES);
            end else if (st_q.blank_cnt != '0) begin
                st_d.blank_cnt = st_q.blank_cnt - 1'b1;
            end
            // Comparator only counts once blanking has run out
            if (st_q.oc_sync[1] && st_q.blank_cnt == '0 && !chop_edge) begin
                st_d.oc_latch = 1'b1;
            end
            if (st_q.ot_sync[1]) begin
                st_d.ot_latch = 1'b1;
            end
            st_d.drive = {pair_a, pair_b};
        end
    end

    // rstn models the internal power-on reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            // Synchronisers start low, so the reset pin reads as held
            // for two clocks after power-on and restarts the excitation
            st_q.rst_sync <= '0;
            st_q.ph_s1 <= `SPDPC_PHASE_IDLE;
            st_q.ph_s2 <= `SPDPC_PHASE_IDLE;
            st_q.en_sync <= '0;
            st_q.oc_sync <= '0;
            st_q.ot_sync <= '0;
            st_q.chop_sync <= '0;
            st_q.chop_prev <= 1'b0;
            st_q.blank_cnt <= '0;
            st_q.oc_latch <= 1'b0;
            st_q.ot_latch <= 1'b0;
            st_q.drive <= `SPDPC_DRIVE_INIT;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Windings gate off on fault or enable low; gating is after the drive flops
    // so a fault cuts current in the cycle it latches
    assign gate_open = st_q.en_sync[1] & ~st_q.oc_latch & ~st_q.ot_latch;
    genvar gi;
    generate
        for (gi = 0; gi < `SPDPC_WINDINGS; gi++) begin : g_wind
            // Each winding gated on its own: no path bypasses a latched fault
            assign winding_on[gi] = gate_open & st_q.drive[gi];
        end
    endgenerate
    assign fault_oc = st_q.oc_latch;
    assign fault_ot = st_q.ot_latch;
    assign link.fault_out = 1'b0;
    assign link.fault_oe = st_q.oc_latch | st_q.ot_latch;
endmodule
`default_nettype wire

// *** verilog/spdpc_defs.svh ***
// Purpose: Constants for the stepper drive protection control block
// Assumes: 100 MHz clk_sys
// Notes: Times in ns, cycle counts derived from them
`ifndef SPDPC_DEFS_SVH
`define SPDPC_DEFS_SVH
`define SPDPC_CLK_PERIOD_NS 10
`define SPDPC_BLANK_TIME_NS 5500
// Blanking is a least time: round up
`define SPDPC_BLANK_CYCLES ((`SPDPC_BLANK_TIME_NS + `SPDPC_CLK_PERIOD_NS - 1) / `SPDPC_CLK_PERIOD_NS)
`define SPDPC_BLANK_W 10
`define SPDPC_PERIOD_W 16
`define SPDPC_PHASE_IDLE 4'hF
`define SPDPC_EXC_INIT 2'h0
// Phase inputs as seen with A and BB asserted (active low)
`define SPDPC_PHASE_INIT 4'h6
// Winding drive {A,AB,B,BB} with A and BB energised
`define SPDPC_DRIVE_INIT 4'h9
`define SPDPC_WINDINGS 4
`endif

// *** verilog/spdpc_pkg.sv ***
// Purpose: Types for the stepper drive protection control block
// Assumes: Constants live in spdpc_defs.svh
// Notes: Used by the step controller only; the driver does not import it
package spdpc_pkg;
    typedef enum logic [1:0] {
        SPDPC_CTL_IDLE,
        SPDPC_CTL_RUN,
        SPDPC_CTL_SLOW
    } spdpc_ctl_state_t;
endpackage

// *** verilog/spdpc_if.sv ***
// Purpose: Link between step controller and driver control logic
// Assumes: Fault line is open drain, pulled up when nobody drives it
// Notes: Phase and reset lines are active low
`timescale 1ns/1ps
`default_nettype none
interface spdpc_if;
    logic phase_a_drive_low;
    logic phase_a_bar_drive_low;
    logic phase_b_drive_low;
    logic phase_b_bar_drive_low;
    logic system_reset_low;
    logic enable;
    logic fault_out;
    logic fault_oe;
    logic fault_low;
    // Open-drain resolution: pulled high unless the driver pulls low
    assign fault_low = fault_oe ? fault_out : 1'b1;
    modport device (
        input phase_a_drive_low, phase_a_bar_drive_low, phase_b_drive_low, phase_b_bar_drive_low,
        input system_reset_low, enable,
        output fault_out, fault_oe
    );
    modport host (
        output phase_a_drive_low, phase_a_bar_drive_low, phase_b_drive_low, phase_b_bar_drive_low,
        output system_reset_low, enable,
        input fault_low
    );
endinterface
`default_nettype wire

// *** verilog/spdpc_host.sv ***
// Purpose: Step controller: phase sequencing with slow-down, reset and enable
// Assumes: Software drives plain register port; one clock
// Notes: Full-step 2-phase sequence only
`timescale 1ns/1ps
`default_nettype none
`include "spdpc_defs.svh"
`define SPDPC_REG_CTRL 4'h0
`define SPDPC_REG_PERIOD 4'h4
`define SPDPC_REG_STATUS 4'h8
module spdpc_host (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    spdpc_if.host link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic supply_ok
);
    typedef struct packed {
        spdpc_pkg::spdpc_ctl_state_t st;
        logic enable;
        logic run_req;
        logic dir;
        logic rst_req;
        logic [1:0] rst_seq;
        logic [`SPDPC_PERIOD_W-1:0] period;
        logic [`SPDPC_PERIOD_W-1:0] cur_period;
        logic [`SPDPC_PERIOD_W-1:0] tick;
        logic [1:0] step;
        logic [1:0] flt_sync;
        logic [31:0] rdata;
    } spdpc_host_state_t;

    spdpc_host_state_t h_q;
    spdpc_host_state_t h_d;
    logic step_now;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        h_d = h_q;
        h_d.flt_sync = {h_q.flt_sync[0], link.fault_low};
        h_d.rdata = '0;
        step_now = (h_q.tick == '0);
        if (wr && addr == `SPDPC_REG_CTRL) begin
            h_d.enable = wdata[0];
            h_d.run_req = wdata[1];
            h_d.dir = wdata[2];
            h_d.rst_req = wdata[3];
        end
        if (wr && addr == `SPDPC_REG_PERIOD) begin
            h_d.period = wdata[`SPDPC_PERIOD_W-1:0];
        end
        if (rd && addr == `SPDPC_REG_CTRL) begin
            h_d.rdata = {28'h0000000, h_q.rst_req, h_q.dir, h_q.run_req, h_q.enable};
        end else if (rd && addr == `SPDPC_REG_PERIOD) begin
            h_d.rdata = {16'h0000, h_q.period};
        end else if (rd && addr == `SPDPC_REG_STATUS) begin
            h_d.rdata = {26'h0000000, ~h_q.flt_sync[1], h_q.rst_seq != 2'h0, h_q.step, h_q.st};
        end
        // Reset pulse: high, low, high
        if (h_q.rst_req && h_q.rst_seq == 2'h0) begin
            h_d.rst_seq = 2'h1;
            h_d.rst_req = 1'b0;
        end else if (h_q.rst_seq != 2'h0) begin
            h_d.rst_seq = h_q.rst_seq + 2'h1;
        end
        case (h_q.st)
            spdpc_pkg::SPDPC_CTL_IDLE: begin
                h_d.cur_period = h_q.period;
                h_d.tick = h_q.period;
                if (h_q.run_req) begin
                    h_d.st = spdpc_pkg::SPDPC_CTL_RUN;
                end
            end
            spdpc_pkg::SPDPC_CTL_RUN, spdpc_pkg::SPDPC_CTL_SLOW: begin
                h_d.tick = h_q.tick - 1'b1;
                if (step_now) begin
                    h_d.step = h_q.dir ? h_q.step - 2'h1 : h_q.step + 2'h1;
                    h_d.tick = h_q.cur_period;
                    if (!h_q.run_req) begin
                        // Stretch the period until it has doubled, then stop
                        h_d.st = spdpc_pkg::SPDPC_CTL_SLOW;
                        h_d.cur_period = h_q.cur_period + (h_q.cur_period >> 2);
                        if (h_q.st == spdpc_pkg::SPDPC_CTL_SLOW && h_q.cur_period >= (h_q.period << 1)) begin
                            h_d.st = spdpc_pkg::SPDPC_CTL_IDLE;
                        end
                    end else begin
                        h_d.st = spdpc_pkg::SPDPC_CTL_RUN;
                        h_d.cur_period = h_q.period;
                    end
                end
            end
            default: h_d.st = spdpc_pkg::SPDPC_CTL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            h_q <= '0;
            h_q.flt_sync <= 2'h3;
        end else if (clk_en) begin
            h_q <= h_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Step 0 = A and BB, matching the driver's reset state; one phase per pair
    assign link.phase_a_drive_low = ~(h_q.step == 2'h0 || h_q.step == 2'h1);
    assign link.phase_a_bar_drive_low = ~(h_q.step == 2'h2 || h_q.step == 2'h3);
    assign link.phase_b_drive_low = ~(h_q.step == 2'h1 || h_q.step == 2'h2);
    assign link.phase_b_bar_drive_low = ~(h_q.step == 2'h0 || h_q.step == 2'h3);
    assign link.system_reset_low = (h_q.rst_seq != 2'h2);
    assign link.enable = h_q.enable & supply_ok;
    assign rdata = h_q.rdata;
endmodule
`default_nettype wire

// *** bench/spdpc_link_chk.sv ***
// Purpose: Link-level checks between step controller and driver control logic
// Assumes: One clock; fault reset passes a two-flop synchroniser in the driver
// Notes: Sees only the link signals, so winding gating is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module spdpc_link_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic phase_a_drive_low,
    input wire logic phase_a_bar_drive_low,
    input wire logic phase_b_drive_low,
    input wire logic phase_b_bar_drive_low,
    input wire logic system_reset_low,
    input wire logic enable,
    input wire logic fault_out,
    input wire logic fault_oe,
    input wire logic fault_low
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_pulse_low;
        !system_reset_low;
    endsequence
    sequence s_pulse_back;
        system_reset_low;
    endsequence
    // Four quiet cycles of reset pin: covers the synchroniser delay
    sequence s_reset_quiet;
        system_reset_low && $past(system_reset_low) && $past(system_reset_low, 2) && $past(system_reset_low, 3);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_od_never_high: assert property (fault_oe |-> fault_out == 1'b0)
        else $error("fault line driven high");
    a_fault_pulls_low: assert property (fault_oe |-> !fault_low)
        else $error("fault line not low while fault held");
    a_idle_line_high: assert property (!fault_oe |-> fault_low)
        else $error("fault line low with no fault");
    a_fault_latch_holds: assert property (fault_oe ##0 s_reset_quiet |=> fault_oe)
        else $error("fault dropped without reset");
    a_reset_pulse_shape: assert property ($fell(system_reset_low) |-> s_pulse_low ##1 s_pulse_back)
        else $error("reset pulse not one cycle low");
    a_pair_a_excl: assert property (!(!phase_a_drive_low && !phase_a_bar_drive_low))
        else $error("phase A pair both asserted");
    a_pair_b_excl: assert property (!(!phase_b_drive_low && !phase_b_bar_drive_low))
        else $error("phase B pair both asserted");
    a_start_a_bb: assert property (disable iff (1'b0) $rose(rstn) |-> {phase_a_drive_low,
        phase_a_bar_drive_low, phase_b_drive_low, phase_b_bar_drive_low} == 4'h6)
        else $error("start excitation not A and BB");
    a_enable_off_reset: assert property (disable iff (1'b0) !rstn |=> !enable)
        else $error("enable high after reset");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench joining step controller and driver logic
// Assumes: Both ends clocked by clk_sys at 100 MHz
// Notes: Software side talks to the controller through its register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, rstn, wr, rd, supply_ok, chop_start, over_current_raw, over_temp_raw;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] winding_on;
    logic fault_oc, fault_ot;
    int n_fail = 0;
    int total_checks = 0;
    int cycle_count = 0;
    spdpc_if spdpc_if_inst ();
    spdpc_host spdpc_host_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .link(spdpc_if_inst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .supply_ok(supply_ok));
    spdpc_device spdpc_device_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .link(spdpc_if_inst),
        .chop_start(chop_start), .over_current_raw(over_current_raw), .over_temp_raw(over_temp_raw),
        .winding_on(winding_on), .fault_oc(fault_oc), .fault_ot(fault_ot));
    spdpc_link_chk spdpc_link_chk_inst (.clk_sys(clk_sys), .rstn(rstn),
        .phase_a_drive_low(spdpc_if_inst.phase_a_drive_low),
        .phase_a_bar_drive_low(spdpc_if_inst.phase_a_bar_drive_low),
        .phase_b_drive_low(spdpc_if_inst.phase_b_drive_low),
        .phase_b_bar_drive_low(spdpc_if_inst.phase_b_bar_drive_low),
        .system_reset_low(spdpc_if_inst.system_reset_low), .enable(spdpc_if_inst.enable),
        .fault_out(spdpc_if_inst.fault_out), .fault_oe(spdpc_if_inst.fault_oe),
        .fault_low(spdpc_if_inst.fault_low));
    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Settle past the edge so checks never race the design's updates
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_start;
        chk("winding", winding_on, 32'h0);
        rd_reg(4'hC);
        chk("unmapped", rd_val, 32'h0);
        wr_reg(4'h0, 32'h1);
        cyc(4);
        chk("enable_no_supply", spdpc_if_inst.enable, 32'h0);
        @(posedge clk_sys) supply_ok <= 1'b1;
        cyc(8);
        chk("enable", spdpc_if_inst.enable, 32'h1);
        chk("winding_start", winding_on, 32'h9);
    endtask
    task t_run;
        wr_reg(4'h4, 32'h8);
        wr_reg(4'h0, 32'h3);
        repeat (100) begin
            cyc(1);
            chk("pair_a", winding_on[3] ^ winding_on[2], 32'h1);
            chk("pair_b", winding_on[1] ^ winding_on[0], 32'h1);
        end
        wr_reg(4'h0, 32'h0);
        cyc(8);
        chk("winding_off", winding_on, 32'h0);
        // Frozen inputs: overcurrent while disabled must leave no fault
        @(posedge clk_sys) over_current_raw <= 1'b1;
        cyc(700);
        chk("frozen_oc", fault_oc, 32'h0);
        @(posedge clk_sys) over_current_raw <= 1'b0;
    endtask
    task t_oc;
        wr_reg(4'h0, 32'h3);
        cyc(8);
        @(posedge clk_sys) chop_start <= 1'b1;
        over_current_raw <= 1'b1;
        cyc(500);
        chk("blanked_oc", fault_oc, 32'h0);
        cyc(100);
        chk("oc_trip", fault_oc, 32'h1);
        chk("fault_line", spdpc_if_inst.fault_low, 32'h0);
        chk("winding_oc", winding_on, 32'h0);
        @(posedge clk_sys) over_current_raw <= 1'b0;
        chop_start <= 1'b0;
        cyc(20);
        chk("oc_latched", fault_oc, 32'h1);
        wr_reg(4'h0, 32'hB);
        cyc(10);
        chk("oc_cleared", fault_oc, 32'h0);
        chk("fault_line_idle", spdpc_if_inst.fault_low, 32'h1);
    endtask
    task t_ot;
        @(posedge clk_sys) over_temp_raw <= 1'b1;
        cyc(3);
        @(posedge clk_sys) over_temp_raw <= 1'b0;
        cyc(5);
        chk("ot_trip", fault_ot, 32'h1);
        chk("winding_ot", winding_on, 32'h0);
        chk("fault_line_ot", spdpc_if_inst.fault_low, 32'h0);
        @(posedge clk_sys) rstn <= 1'b0;
        @(posedge clk_sys) rstn <= 1'b1;
        cyc(2);
        chk("ot_por_clear", fault_ot, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Whole run needs about 1500 cycles; over thirteen times that means a hang
    always @(posedge clk_sys) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    initial begin
        rstn = 1'b0;
        {wr, rd, supply_ok, chop_start, over_current_raw, over_temp_raw} = 6'h00;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        cyc(1);
        t_start;
        t_run;
        t_oc;
        t_ot;
        report_and_stop;
    end
endmodule
`default_nettype wire
